// [common/swc_pkg.sv]
// Purpose: shared constants and types for the sleep and wake controller
// Assumes: core clock of 50 MHz
// Notes: times are given in their own unit, settle cycle count derived here, remote wake cycle count in swc_top
package swc_pkg;

  // core clock period in picoseconds
  localparam int CLK_PERIOD_PS = 20000;

  // reset values of the configuration that software may change
  localparam logic WAKE_POL_RST = 1'b0;  // device wake input active low
  localparam logic HOST_POL_RST = 1'b1;  // host wake output active high

  // width of the spi idle timeout and low-power timers
  localparam int IDLE_W = 16;
  localparam int TMR_W = 16;

  // transport selection codes
  typedef enum logic [1:0] {
    SWC_XPORT_UART,
    SWC_XPORT_USB,
    SWC_XPORT_SPI,
    SWC_XPORT_PINS
  } swc_xport_e;

  // power states of the controller
  typedef enum logic [2:0] {
    SWC_ACTIVE,
    SWC_ENTER,
    SWC_SLEEP,
    SWC_EVENT,
    SWC_WAKING
  } swc_state_e;

  // settle time between power-down and clock stop, and wake power-up
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYC =
    (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // usb remote wake-up k-state length, least time 1 ms
  localparam int RWAKE_US = 1000;

endpackage : swc_pkg

// [rtl/swc_sync.sv]
// Purpose: two flip-flop level synchroniser, several bits wide
// Assumes: inputs are quasi-static levels from another domain
// Notes: the first stage is read by the second stage only
`timescale 1ns/100ps
module swc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // first capture stage
  logic [WIDTH-1:0] meta;

  // two stage register chain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : swc_sync

// [rtl/swc_lpo_timer.sv]
// Purpose: low-power-oscillator tick timer for periodic scan and sniff
// Assumes: lpo_tick is a one-cycle enable already in the core domain
// Notes: counts ticks and pulses event_due at each period end
`timescale 1ns/100ps
module swc_lpo_timer #(
  parameter int WIDTH = swc_pkg::TMR_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic lpo_tick,
  input wire logic [WIDTH-1:0] period,
  output logic event_due
);

  import swc_pkg::*;

  // timer state
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic due;
  } swc_tmr_s;

  swc_tmr_s st;
  swc_tmr_s next_st;

  initial begin
    if (WIDTH < 2) $error("timer width too small");
  end

  // count lpo ticks and fire at the programmed period
  always_comb begin
    next_st = st;
    next_st.due = 1'b0;
    if (!enable) begin
      next_st.count = '0;
    end else if (lpo_tick) begin
      if (st.count + WIDTH'(1) >= period) begin
        next_st.count = '0;
        next_st.due = 1'b1;
      end else begin
        next_st.count = st.count + WIDTH'(1);
      end
    end
  end

  // register the timer state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign event_due = st.due;

endmodule : swc_lpo_timer

// [rtl/swc_top.sv]
// Purpose: sleep and wake controller of the baseband core
// Assumes: lpo edges come as a raw pin, sampled on core_clk
// Notes: core_clk is gated by the power manager outside, not here
//
// Summary of operation
// - sleep powers down nonessential blocks, keeps core
// - sleep timer from lpo wakes on time or host
// - periodic scan or sniff wakes, then sleeps again
// - transports idle in sleep, host wake always accepted
// - host wake during session keeps device awake
// - withdrawn wake request lets device sleep
// - device drives host wake output
// - uart cts and rts carry wake requests
// - usb honours suspend, resume and remote wake
// - spi idle while select deasserted, sleep after timeout
// - asserting spi select wakes the device
// - spi interrupt wakes sleeping host when data pending
// - separate power-downs for tx, rx, pll, pa
// - device wake polarity selectable, default active low
// - host wake polarity selectable
`timescale 1ns/100ps
module swc_top #(
  parameter int IDLE_W = swc_pkg::IDLE_W,
  parameter int TMR_W = swc_pkg::TMR_W,
  parameter int RWAKE_CYC = swc_pkg::RWAKE_US * 50
) (
  input wire logic core_clk,
  input wire logic resetn,
  // configuration from firmware
  input wire logic sleep_enable,
  input wire swc_pkg::swc_xport_e xport_mode,
  input wire logic wake_pol_high,
  input wire logic host_pol_high,
  input wire logic spi_idle_sleep_en,
  input wire logic [IDLE_W-1:0] spi_idle_time,
  input wire logic session_enable,
  input wire logic [TMR_W-1:0] session_period,
  input wire logic event_done,
  input wire logic host_data_pending,
  input wire logic host_asleep,
  input wire logic [1:0] radio_use,
  // pins from the host and oscillator
  input wire logic low_power_osc,
  input wire logic device_wake_in,
  input wire logic uart_cts,
  input wire logic usb_suspend,
  input wire logic usb_resume,
  input wire logic serial_select_n,
  // power and wake outputs
  output logic host_wake_out,
  output logic uart_rts,
  output logic usb_remote_wake,
  output logic serial_int,
  output logic nonessential_pwr_off,
  output logic nonessential_clk_stop,
  output logic transport_idle,
  output logic event_active,
  output logic asleep,
  output logic tx_pd,
  output logic rx_pd,
  output logic pll_pd,
  output logic pa_pd
);

  import swc_pkg::*;

  initial begin
    if (IDLE_W < 2 || TMR_W < 2) $error("timer widths too small");
    if (RWAKE_CYC < 1) $error("remote wake length must be positive");
  end

  // reset release chain
  logic rst_m;
  logic rst_n;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // synchronised pin levels: lpo, wake, cts, suspend, resume, select
  logic [5:0] pins_s;
  // reset to idle levels: lpo low, wake pin inactive at default polarity, select deasserted,
  // so no false lpo edge and, outside usb mode, no false wake request follow reset
  swc_sync #(
    .WIDTH(6),
    .RST_VAL({1'b0, ~WAKE_POL_RST, 3'b000, 1'b1})
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({low_power_osc, device_wake_in, uart_cts, usb_suspend,
      usb_resume, serial_select_n}),
    .sync_out(pins_s)
  );

  logic lpo_s;
  logic wake_pin_s;
  logic cts_s;
  logic susp_s;
  logic resume_s;
  logic sel_n_s;
  assign lpo_s = pins_s[5];
  assign wake_pin_s = pins_s[4];
  assign cts_s = pins_s[3];
  assign susp_s = pins_s[2];
  assign resume_s = pins_s[1];
  assign sel_n_s = pins_s[0];

  // all module state except the reset release chain
  typedef struct packed {
    swc_state_e state;
    logic lpo_d;
    logic [IDLE_W-1:0] idle_cnt;
    logic [$clog2(SETTLE_CYC+1)-1:0] settle;
    logic [31:0] rwake_cnt;
    logic host_wake;
    logic serial_int;
    logic [3:0] pd;
  } swc_st_s;

  swc_st_s st;
  swc_st_s next_st;

  // lpo rising edge as a core-clock enable
  logic lpo_tick;
  assign lpo_tick = lpo_s & ~st.lpo_d;

  // periodic scan or sniff timer
  logic event_due;
  swc_lpo_timer #(.WIDTH(TMR_W)) u_tmr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(session_enable),
    .lpo_tick(lpo_tick),
    .period(session_period),
    .event_due(event_due)
  );

  // host wake request from the selected transport, polarity applied
  logic pin_req;
  logic host_req;
  assign pin_req = wake_pin_s ~^ wake_pol_high;
  always_comb begin
    case (xport_mode)
      SWC_XPORT_UART: host_req = pin_req | cts_s;
      SWC_XPORT_USB: host_req = pin_req | resume_s | ~susp_s;
      SWC_XPORT_SPI: host_req = pin_req | ~sel_n_s;
      default: host_req = pin_req;
    endcase
  end

  // spi idle sleep permission after programmed idle time
  logic spi_idle_ok;
  assign spi_idle_ok = (xport_mode != SWC_XPORT_SPI) ||
    (spi_idle_sleep_en && st.idle_cnt >= spi_idle_time);

  // sleep allowed: enabled, no request, spi idle time passed in spi mode
  logic can_sleep;
  assign can_sleep = sleep_enable && !host_req && spi_idle_ok;

  // next state logic
  always_comb begin
    next_st = st;
    next_st.lpo_d = lpo_s;
    // idle timer restarts while select is asserted
    if (!sel_n_s) begin
      next_st.idle_cnt = '0;
    end else if (st.idle_cnt != {IDLE_W{1'b1}}) begin
      next_st.idle_cnt = st.idle_cnt + IDLE_W'(1);
    end
    // device wants host attention while data is pending
    next_st.host_wake = host_data_pending;
    next_st.serial_int = (xport_mode == SWC_XPORT_SPI) &&
      host_asleep && host_data_pending;
    // usb remote wake pulse while suspended with data
    if (st.rwake_cnt != 32'h0) begin
      next_st.rwake_cnt = st.rwake_cnt - 32'h1;
    end else if (xport_mode == SWC_XPORT_USB && susp_s &&
      host_data_pending && !st.host_wake) begin
      next_st.rwake_cnt = 32'(RWAKE_CYC);
    end
    case (st.state)
      SWC_ACTIVE: begin
        next_st.pd = {2'b00, ~radio_use};
        if (can_sleep && !event_active_w()) begin
          next_st.state = SWC_ENTER;
          next_st.settle = '0;
        end
      end
      SWC_ENTER: begin
        next_st.pd = 4'hF;
        if (host_req) begin
          next_st.state = SWC_ACTIVE;
        end else if (32'(st.settle) + 1 >= SETTLE_CYC) begin
          next_st.state = SWC_SLEEP;
        end else begin
          next_st.settle = st.settle + 1'b1;
        end
      end
      SWC_SLEEP: begin
        next_st.pd = 4'hF;
        if (host_req) begin
          next_st.state = SWC_WAKING;
          next_st.settle = '0;
        end else if (event_due) begin
          next_st.state = SWC_EVENT;
        end
      end
      SWC_EVENT: begin
        next_st.pd = {2'b00, ~radio_use};
        if (event_done) begin
          // stay awake when host requested it meanwhile
          next_st.state = host_req ? SWC_ACTIVE : SWC_ENTER;
          next_st.settle = '0;
        end
      end
      SWC_WAKING: begin
        if (32'(st.settle) + 1 >= SETTLE_CYC) begin
          next_st.state = SWC_ACTIVE;
        end else begin
          next_st.settle = st.settle + 1'b1;
        end
      end
      default: next_st.state = SWC_ACTIVE;
    endcase
  end

  // session timer event_due pulse, checked while awake before sleep entry
  function automatic logic event_active_w();
    return event_due;
  endfunction : event_active_w

  // register all state except the reset release chain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{state: SWC_ACTIVE, lpo_d: 1'b0, idle_cnt: '0, settle: '0,
        rwake_cnt: 32'h0, host_wake: 1'b0, serial_int: 1'b0,
        pd: 4'h0};
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign asleep = (st.state == SWC_SLEEP);
  assign nonessential_pwr_off = (st.state == SWC_SLEEP);
  assign nonessential_clk_stop = (st.state == SWC_SLEEP);
  assign transport_idle = (st.state == SWC_SLEEP);
  assign event_active = (st.state == SWC_EVENT);
  assign host_wake_out = st.host_wake ~^ host_pol_high;
  assign uart_rts = (xport_mode == SWC_XPORT_UART) & st.host_wake;
  assign usb_remote_wake = (st.rwake_cnt != 32'h0);
  assign serial_int = st.serial_int;
  assign tx_pd = st.pd[0];
  assign rx_pd = st.pd[1];
  assign pll_pd = st.pd[2];
  assign pa_pd = st.pd[3];

  // sequence for the sleep entry path
  sequence enter_seq;
    st.state == SWC_ENTER && !host_req;
  endsequence

  // no sleep while a host request stands
  no_sleep_req_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    host_req && st.state == SWC_SLEEP |=> st.state == SWC_WAKING)
    else $error("host request did not wake device");
  sleep_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.state == SWC_ACTIVE && (!sleep_enable || host_req) |=>
    st.state == SWC_ACTIVE)
    else $error("sleep entered without permission");
  sleep_power_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    asleep |-> nonessential_pwr_off && nonessential_clk_stop &&
    pd_all())
    else $error("sleep without power down");
  event_wake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.state == SWC_SLEEP && event_due && !host_req |=>
    st.state == SWC_EVENT)
    else $error("periodic event missed");
  stay_awake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.state == SWC_EVENT && event_done && host_req |=>
    st.state == SWC_ACTIVE)
    else $error("slept between events despite request");
  spi_int_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    xport_mode == SWC_XPORT_SPI && host_asleep && host_data_pending
    ##1 xport_mode == SWC_XPORT_SPI |-> serial_int)
    else $error("serial interrupt not raised");
  idle_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sel_n_s |=> st.idle_cnt == '0)
    else $error("idle timer not restarted");
  enter_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    enter_seq |=> st.state inside {SWC_ENTER, SWC_SLEEP})
    else $error("sleep entry broken");

  function automatic logic pd_all();
    return tx_pd & rx_pd & pll_pd & pa_pd;
  endfunction : pd_all

endmodule : swc_top

// [verification/swc_host_model.sv]
// Purpose: host side of the wake handshake for the controller bench
// Assumes: one core clock; the host moves its pins after a rising edge
// Notes: wake pin used in pins mode, cts in uart mode, select in spi
`timescale 1ns/100ps
module swc_host_model (
  input wire logic core_clk,
  input wire logic want_wake, // host wants the device awake
  input wire logic pol_high, // level that means wake on the pin
  input wire swc_pkg::swc_xport_e mode, // transport in use
  output logic device_wake_in,
  output logic uart_cts,
  output logic serial_select_n
);
  import swc_pkg::*;
  logic on_pins; // request carried by the dedicated pin
  assign on_pins = want_wake && (mode == SWC_XPORT_PINS);
  // no request on any line at time zero
  initial begin
    device_wake_in = !pol_high;
    uart_cts = 1'b0;
    serial_select_n = 1'b1;
  end
  // requests are levels, held until the bench withdraws them
  always @(posedge core_clk) begin
    device_wake_in <= on_pins ^ !pol_high;
    uart_cts <= want_wake && (mode == SWC_XPORT_UART);
    serial_select_n <= !(want_wake && (mode == SWC_XPORT_SPI));
  end
endmodule : swc_host_model

// [verification/swc_top_bench.sv]
// Purpose: self-checking bench for the sleep and wake controller
// Assumes: the host model turns want_wake into the transport's request
// Notes: every wait is bounded; remote wake length shortened to 20
`timescale 1ns/100ps
module swc_top_bench;
  import swc_pkg::*;
  logic core_clk, resetn, sleep_enable, wake_pol_high, host_pol_high;
  logic spi_idle_sleep_en, session_enable, event_done, host_data_pending;
  logic host_asleep, low_power_osc, usb_suspend, usb_resume, want_wake;
  logic [IDLE_W-1:0] spi_idle_time;
  logic [TMR_W-1:0] session_period;
  logic [1:0] radio_use;
  logic [2:0] lpo_div; // slow oscillator divider
  swc_xport_e xport_mode;
  logic device_wake_in, uart_cts, serial_select_n, host_wake_out, uart_rts;
  logic usb_remote_wake, serial_int, nonessential_pwr_off, asleep;
  logic nonessential_clk_stop, transport_idle, event_active;
  logic tx_pd, rx_pd, pll_pd, pa_pd;
  int bad_count, cmp_count, cyc;

  swc_top #(.RWAKE_CYC(20)) dut (.core_clk, .resetn, .sleep_enable,
    .xport_mode, .wake_pol_high, .host_pol_high, .spi_idle_sleep_en,
    .spi_idle_time, .session_enable, .session_period, .event_done,
    .host_data_pending, .host_asleep, .radio_use, .low_power_osc,
    .device_wake_in, .uart_cts, .usb_suspend, .usb_resume,
    .serial_select_n, .host_wake_out, .uart_rts, .usb_remote_wake,
    .serial_int, .nonessential_pwr_off, .nonessential_clk_stop,
    .transport_idle, .event_active, .asleep, .tx_pd, .rx_pd, .pll_pd,
    .pa_pd);

  swc_host_model host (.core_clk, .want_wake, .pol_high(wake_pol_high),
    .mode(xport_mode), .device_wake_in, .uart_cts, .serial_select_n);

  // core clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // slow oscillator of 8 core cycles, and the hang limit
  always @(posedge core_clk) begin
    lpo_div <= lpo_div + 3'h1;
    low_power_osc <= lpo_div[2];
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      print_verdict();
    end
  end

  // counts, verdict and end of run
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // compare one output bit
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // settle at falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  // wait for asleep (sel 0) or event_active (sel 1) to reach v
  task automatic wt(input logic sel, input logic v, input int n);
    int k;
    k = 0;
    while (((sel ? event_active : asleep) !== v) && k < n) begin
      tick(1);
      k++;
    end
    chk(sel ? event_active : asleep, v);
  endtask : wt

  // one-cycle end of a scan or sniff event
  task automatic done_pulse();
    @(posedge core_clk);
    event_done <= 1'b1;
    @(posedge core_clk);
    event_done <= 1'b0;
  endtask : done_pulse

  // main sequence
  initial begin
    resetn = 1'b0;
    sleep_enable = 1'b0;
    xport_mode = SWC_XPORT_PINS;
    wake_pol_high = 1'b0;
    host_pol_high = 1'b1;
    spi_idle_sleep_en = 1'b0;
    spi_idle_time = 16'h0028;
    session_enable = 1'b0;
    session_period = 16'h0003;
    event_done = 1'b0;
    host_data_pending = 1'b0;
    host_asleep = 1'b0;
    radio_use = 2'h0;
    usb_suspend = 1'b1;
    usb_resume = 1'b0;
    want_wake = 1'b0;
    lpo_div = 3'h0;
    low_power_osc = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    tick(34);
    chk(asleep, 1'b0);
    @(posedge core_clk);
    sleep_enable <= 1'b1;
    wt(0, 1'b1, 30);
    chk(nonessential_pwr_off, 1'b1);
    chk(nonessential_clk_stop, 1'b1);
    chk(transport_idle, 1'b1);
    @(posedge core_clk);
    want_wake <= 1'b1;
    wt(0, 1'b0, 20);
    chk(nonessential_clk_stop, 1'b0);
    tick(30);
    chk(asleep, 1'b0);
    // polarity switched while awake, so no false request in sleep
    @(posedge core_clk);
    wake_pol_high <= 1'b1;
    want_wake <= 1'b0;
    wt(0, 1'b1, 30);
    // high-active wake pin: a high level must wake
    @(posedge core_clk);
    want_wake <= 1'b1;
    wt(0, 1'b0, 20);
    // uart: cts carries the request
    @(posedge core_clk);
    xport_mode <= SWC_XPORT_UART;
    wake_pol_high <= 1'b0;
    want_wake <= 1'b0;
    wt(0, 1'b1, 40);
    @(posedge core_clk);
    want_wake <= 1'b1;
    wt(0, 1'b0, 20);
    @(posedge core_clk);
    host_data_pending <= 1'b1;
    tick(4);
    chk(host_wake_out, 1'b1);
    chk(uart_rts, 1'b1);
    @(posedge core_clk);
    host_pol_high <= 1'b0;
    radio_use <= 2'h1;
    tick(4);
    chk(host_wake_out, 1'b0);
    chk(tx_pd, 1'b0);
    chk(rx_pd, 1'b1);
    chk(pll_pd, 1'b0);
    chk(pa_pd, 1'b0);
    @(posedge core_clk);
    host_data_pending <= 1'b0;
    radio_use <= 2'h2;
    tick(4);
    chk(tx_pd, 1'b1);
    chk(rx_pd, 1'b0);
    // spi: select held, then released; idle time counts from release
    @(posedge core_clk);
    xport_mode <= SWC_XPORT_SPI;
    tick(10);
    @(posedge core_clk);
    spi_idle_sleep_en <= 1'b1;
    want_wake <= 1'b0;
    tick(25);
    chk(asleep, 1'b0);
    wt(0, 1'b1, 40);
    @(posedge core_clk);
    host_asleep <= 1'b1;
    host_data_pending <= 1'b1;
    tick(4);
    chk(serial_int, 1'b1);
    @(posedge core_clk);
    host_data_pending <= 1'b0;
    want_wake <= 1'b1;
    wt(0, 1'b0, 20);
    // periodic events while asleep
    @(posedge core_clk);
    xport_mode <= SWC_XPORT_PINS;
    want_wake <= 1'b0;
    session_enable <= 1'b1;
    wt(0, 1'b1, 40);
    wt(1, 1'b1, 60);
    done_pulse();
    wt(0, 1'b1, 20);
    wt(1, 1'b1, 60);
    @(posedge core_clk);
    want_wake <= 1'b1;
    tick(4);
    done_pulse();
    tick(40);
    chk(asleep, 1'b0);
    // usb: not suspended keeps awake, resume wakes
    @(posedge core_clk);
    session_enable <= 1'b0;
    xport_mode <= SWC_XPORT_USB;
    want_wake <= 1'b0;
    usb_suspend <= 1'b0;
    tick(30);
    chk(asleep, 1'b0);
    @(posedge core_clk);
    usb_suspend <= 1'b1;
    wt(0, 1'b1, 40);
    // suspended with data pending: remote wake for 20 cycles
    @(posedge core_clk);
    host_data_pending <= 1'b1;
    tick(2);
    chk(usb_remote_wake, 1'b1);
    tick(25);
    chk(usb_remote_wake, 1'b0);
    @(posedge core_clk);
    host_data_pending <= 1'b0;
    usb_resume <= 1'b1;
    wt(0, 1'b0, 20);
    print_verdict();
  end
endmodule : swc_top_bench
